// ==== include/sram_host_pkg.sv ====
package sram_host_pkg;

    localparam int ADDR_WIDTH = 18;
    localparam int DATA_WIDTH = 16;
    localparam int LANE_COUNT = 2;
    localparam int LANE_WIDTH = 8;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int PS_PER_NS = 1000;

    // Timing figures in nanoseconds, fast grade and slow grade.
    localparam int WRITE_CYCLE_FAST_NS = 55;
    localparam int WRITE_CYCLE_SLOW_NS = 70;
    localparam int READ_CYCLE_FAST_NS = 55;
    localparam int READ_CYCLE_SLOW_NS = 70;
    localparam int STROBE_LOW_WIDTH_FAST_NS = 45;
    localparam int STROBE_LOW_WIDTH_SLOW_NS = 60;
    localparam int SELECT_LOW_WIDTH_FAST_NS = 45;
    localparam int SELECT_LOW_WIDTH_SLOW_NS = 60;
    localparam int LANE_LOW_WIDTH_FAST_NS = 45;
    localparam int LANE_LOW_WIDTH_SLOW_NS = 60;
    localparam int DATA_SETUP_FAST_NS = 25;
    localparam int DATA_SETUP_SLOW_NS = 30;
    localparam int STROBE_TO_FLOAT_DELAY_NS = 20;
    localparam int STROBE_HIGH_TO_DRIVE_DELAY_NS = 5;
    localparam int OUTPUT_FLOAT_FAST_NS = 20;
    localparam int OUTPUT_FLOAT_SLOW_NS = 25;
    localparam int DESELECT_TO_RETENTION_DELAY_NS = 0;

    // Cycles from a pin change to the agreed output of the input synchroniser.
    localparam int SYNC_LATENCY = 4;

    localparam int COUNT_WIDTH = 5;

    localparam logic [1:0] LANES_IDLE_N = 2'h3;
    localparam logic [7:0] LANE_ZERO = 8'h00;

    // Least time in whole clock cycles, never below one cycle.
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : min_cycles

    typedef struct packed {
        logic write;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] data;
        logic [LANE_COUNT-1:0] lanes;
    } sram_req_type;

    typedef struct packed {
        logic select_n;
        logic write_n;
        logic out_enable_n;
        logic upper_lane_enable_n;
        logic lower_lane_enable_n;
        logic [ADDR_WIDTH-1:0] address_bus;
        logic [DATA_WIDTH-1:0] data_bus_out;
        logic data_bus_oe;
    } sram_pins_type;

endpackage : sram_host_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk,               // System clock.
    input wire logic i_reset_n,           // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] i_async, // Input from the pins.
    output logic [WIDTH-1:0] o_sync       // Agreed, synchronised value.
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] agreed_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A change is taken only once the second and third stages agree.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            agreed_reg <= '0;
        end else if (stage2_reg == stage3_reg) begin
            agreed_reg <= stage3_reg;
        end
    end

    assign o_sync = agreed_reg;

endmodule : pin_sync

// ==== rtl/sram_write_host.sv ====
`timescale 1ns/1ps
// Function
// - Address changes only while select or write strobe is high.
// - Never drive data while the memory may still drive it.
// - Write strobe stays low at least 45 ns fast, 60 ns slow grade.
// - Select stays low at least 45 ns fast, 60 ns slow grade.
// - Lane enables stay low at least 45 ns fast, 60 ns slow grade.
// - Deselect the memory before retention; 0 ns least delay.
// - After retention wait one read cycle time before a new access.
module sram_write_host #(
    parameter bit SLOW_GRADE = 1'b0
) (
    input wire logic i_clk,                                         // 200 MHz clock.
    input wire logic i_reset_n,                                     // Asynchronous reset, active low.
    input wire logic i_req_valid,                                   // Access request.
    input wire sram_host_pkg::sram_req_type i_req,                  // Access kind, address, data, lanes.
    output logic o_req_ready,                                       // Request may be taken.
    output logic o_rd_valid,                                        // One-cycle read data pulse.
    output logic [sram_host_pkg::DATA_WIDTH-1:0] o_rd_data,         // Read data, disabled lanes zero.
    input wire logic i_retain_req,                                  // Ask for data retention.
    output logic o_retain_ok,                                       // Memory deselected, supply may drop.
    output logic o_select_n,                                        // Chip select, active low.
    output logic o_write_n,                                         // Write strobe, active low.
    output logic o_out_enable_n,                                    // Output enable, active low.
    output logic o_upper_lane_enable_n,                             // Upper lane enable, active low.
    output logic o_lower_lane_enable_n,                             // Lower lane enable, active low.
    output logic [sram_host_pkg::ADDR_WIDTH-1:0] o_address_bus,     // Address pins.
    output logic [sram_host_pkg::DATA_WIDTH-1:0] o_data_bus_out,    // Data pins, driven value.
    output logic o_data_bus_oe,                                     // Data pins driven while high.
    input wire logic [sram_host_pkg::DATA_WIDTH-1:0] i_data_bus_in  // Data pins, sensed value.
);

    localparam int WRITE_CYC_I = sram_host_pkg::min_cycles(SLOW_GRADE ? sram_host_pkg::WRITE_CYCLE_SLOW_NS :
                                                                        sram_host_pkg::WRITE_CYCLE_FAST_NS);
    localparam int READ_CYC_I = sram_host_pkg::min_cycles(SLOW_GRADE ? sram_host_pkg::READ_CYCLE_SLOW_NS :
                                                                       sram_host_pkg::READ_CYCLE_FAST_NS);
    localparam int STROBE_CYC_I = sram_host_pkg::min_cycles(SLOW_GRADE ? sram_host_pkg::STROBE_LOW_WIDTH_SLOW_NS :
                                                                         sram_host_pkg::STROBE_LOW_WIDTH_FAST_NS);
    localparam int FLOAT_IN_CYC_I = sram_host_pkg::min_cycles(sram_host_pkg::STROBE_TO_FLOAT_DELAY_NS);
    localparam int FLOAT_OUT_CYC_I = sram_host_pkg::min_cycles(SLOW_GRADE ? sram_host_pkg::OUTPUT_FLOAT_SLOW_NS :
                                                                            sram_host_pkg::OUTPUT_FLOAT_FAST_NS);
    localparam int RETAIN_CYC_I = sram_host_pkg::min_cycles(sram_host_pkg::DESELECT_TO_RETENTION_DELAY_NS);

    localparam int CW = sram_host_pkg::COUNT_WIDTH;
    localparam logic [CW-1:0] WRITE_LAST = CW'(WRITE_CYC_I - 1);
    localparam logic [CW-1:0] STROBE_LAST = CW'(STROBE_CYC_I - 1);
    localparam logic [CW-1:0] FLOAT_IN_LAST = CW'(FLOAT_IN_CYC_I - 1);
    localparam logic [CW-1:0] FLOAT_OUT_LAST = CW'(FLOAT_OUT_CYC_I - 1);
    localparam logic [CW-1:0] READ_LAST = CW'(READ_CYC_I + sram_host_pkg::SYNC_LATENCY - 1);
    localparam logic [CW-1:0] RECOVER_LAST = CW'(READ_CYC_I - 1);
    localparam logic [CW-1:0] RETAIN_LAST = CW'(RETAIN_CYC_I - 1);
    localparam logic [CW-1:0] COUNT_MAX = {CW{1'b1}};
    localparam logic [CW-1:0] COUNT_ONE = CW'(1);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_CYCLE,
        ST_READ,
        ST_FLOAT,
        ST_RETAIN,
        ST_RECOVER
    } state_type;

    state_type state_reg;
    state_type state_next;
    logic [CW-1:0] elapsed_reg;
    logic [CW-1:0] total_reg;
    sram_host_pkg::sram_req_type req_reg;
    sram_host_pkg::sram_req_type cur_req;
    sram_host_pkg::sram_pins_type pins_reg;
    logic take;
    logic selected_next;
    logic ready_reg;
    logic rd_valid_reg;
    logic [sram_host_pkg::DATA_WIDTH-1:0] rd_data_reg;
    logic retain_ok_reg;
    logic [sram_host_pkg::DATA_WIDTH-1:0] data_sync;

    pin_sync #(
        .WIDTH(sram_host_pkg::DATA_WIDTH)
    ) u_data_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_data_bus_in),
        .o_sync(data_sync)
    );

    // Retention has priority over a pending request.
    assign take = (state_reg == ST_IDLE) && ready_reg && i_req_valid && !i_retain_req;
    assign cur_req = take ? i_req : req_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (i_retain_req) begin
                    state_next = ST_RETAIN;
                end else if (take) begin
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                state_next = req_reg.write ? ST_STROBE : ST_READ;
            end
            ST_STROBE: begin
                if (elapsed_reg == STROBE_LAST) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                state_next = ST_CYCLE;
            end
            ST_CYCLE: begin
                if (total_reg >= WRITE_LAST) begin
                    state_next = ST_IDLE;
                end
            end
            ST_READ: begin
                if (elapsed_reg == READ_LAST) begin
                    state_next = ST_FLOAT;
                end
            end
            ST_FLOAT: begin
                if (elapsed_reg == FLOAT_OUT_LAST) begin
                    state_next = ST_IDLE;
                end
            end
            ST_RETAIN: begin
                if (!i_retain_req && elapsed_reg >= RETAIN_LAST) begin
                    state_next = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (elapsed_reg == RECOVER_LAST) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Elapsed counts cycles in the present state; total counts the whole access.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            elapsed_reg <= '0;
            total_reg <= '0;
        end else begin
            if (state_next != state_reg) begin
                elapsed_reg <= '0;
            end else if (elapsed_reg != COUNT_MAX) begin
                elapsed_reg <= elapsed_reg + COUNT_ONE;
            end
            if (state_next == ST_IDLE || state_next == ST_RETAIN || state_next == ST_RECOVER) begin
                total_reg <= '0;
            end else if (total_reg != COUNT_MAX) begin
                total_reg <= total_reg + COUNT_ONE;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req_reg <= '0;
        end else if (take) begin
            req_reg <= i_req;
        end
    end

    // select held through strobe and hold
    assign selected_next = (state_next == ST_SETUP) || (state_next == ST_STROBE) ||
                           (state_next == ST_HOLD) || (state_next == ST_READ);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pins_reg.select_n <= 1'b1;
            pins_reg.write_n <= 1'b1;
            pins_reg.out_enable_n <= 1'b1;
            pins_reg.upper_lane_enable_n <= 1'b1;
            pins_reg.lower_lane_enable_n <= 1'b1;
            pins_reg.address_bus <= '0;
            pins_reg.data_bus_out <= '0;
            pins_reg.data_bus_oe <= 1'b0;
        end else begin
            pins_reg.select_n <= !selected_next;
            pins_reg.write_n <= (state_next != ST_STROBE);
            pins_reg.out_enable_n <= (state_next != ST_READ);
            if (selected_next) begin
                pins_reg.upper_lane_enable_n <= !cur_req.lanes[1];
                pins_reg.lower_lane_enable_n <= !cur_req.lanes[0];
            end else begin
                pins_reg.upper_lane_enable_n <= sram_host_pkg::LANES_IDLE_N[1];
                pins_reg.lower_lane_enable_n <= sram_host_pkg::LANES_IDLE_N[0];
            end
            // address moves only while strobe high
            if (take) begin
                pins_reg.address_bus <= i_req.addr;
                pins_reg.data_bus_out <= i_req.data;
            end
            pins_reg.data_bus_oe <= (state_reg == ST_STROBE && state_next == ST_STROBE &&
                                     elapsed_reg >= FLOAT_IN_LAST) ||
                                    (state_next == ST_HOLD) || (pins_reg.data_bus_oe && state_next == ST_STROBE);
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= (state_next == ST_IDLE) && !take;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
        end else begin
            rd_valid_reg <= (state_reg == ST_READ) && (state_next == ST_FLOAT);
            if (state_reg == ST_READ && state_next == ST_FLOAT) begin
                rd_data_reg <= {req_reg.lanes[1] ? data_sync[15:8] : sram_host_pkg::LANE_ZERO,
                                req_reg.lanes[0] ? data_sync[7:0] : sram_host_pkg::LANE_ZERO};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            retain_ok_reg <= 1'b0;
        end else begin
            retain_ok_reg <= (state_next == ST_RETAIN);
        end
    end

    assign o_req_ready = ready_reg;
    assign o_rd_valid = rd_valid_reg;
    assign o_rd_data = rd_data_reg;
    assign o_retain_ok = retain_ok_reg;
    assign o_select_n = pins_reg.select_n;
    assign o_write_n = pins_reg.write_n;
    assign o_out_enable_n = pins_reg.out_enable_n;
    assign o_upper_lane_enable_n = pins_reg.upper_lane_enable_n;
    assign o_lower_lane_enable_n = pins_reg.lower_lane_enable_n;
    assign o_address_bus = pins_reg.address_bus;
    assign o_data_bus_out = pins_reg.data_bus_out;
    assign o_data_bus_oe = pins_reg.data_bus_oe;

endmodule : sram_write_host

// ==== bench/sram_write_host_properties.sv ====
`timescale 1ns/1ps
module sram_write_host_properties (
    input wire logic i_clk, // Clock.
    input wire logic i_reset_n, // Reset, active low.
    input wire logic o_retain_ok, // Retention granted.
    input wire logic o_select_n, // Chip select.
    input wire logic o_write_n, // Write strobe.
    input wire logic o_out_enable_n, // Output enable.
    input wire logic o_upper_lane_enable_n, // Upper lane.
    input wire logic o_lower_lane_enable_n, // Lower lane.
    input wire logic [17:0] o_address_bus, // Address pins.
    input wire logic o_data_bus_oe // Host drives data.
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    chk_addr_moves_idle: assert property ($changed(o_address_bus) |-> $past(o_select_n))
        else $error("address moved during an access");
    chk_drive_no_read: assert property (o_data_bus_oe |-> o_out_enable_n && !o_select_n)
        else $error("data driven while memory may drive");
    chk_drive_after_float: assert property ($rose(o_data_bus_oe) |-> !o_write_n && !$past(o_write_n, 4))
        else $error("data driven before memory floated");
    chk_strobe_width: assert property ($fell(o_write_n) |=> !o_write_n [*8])
        else $error("write strobe pulse too short");
    chk_select_width: assert property ($fell(o_select_n) |=> !o_select_n [*8])
        else $error("select pulse too short");
    chk_lower_lane_width: assert property ($fell(o_lower_lane_enable_n) |=> !o_lower_lane_enable_n [*8])
        else $error("lower lane pulse too short");
    chk_upper_lane_width: assert property ($fell(o_upper_lane_enable_n) |=> !o_upper_lane_enable_n [*8])
        else $error("upper lane pulse too short");
    chk_retain_deselect: assert property (o_retain_ok |-> o_select_n && $past(o_select_n))
        else $error("retention granted while selected");
    chk_retain_recovery: assert property ($fell(o_retain_ok) |-> o_select_n [*8] ##1 o_select_n [*3])
        else $error("access too soon after retention");
endmodule : sram_write_host_properties

bind sram_write_host sram_write_host_properties sram_write_host_properties_inst (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .o_retain_ok(o_retain_ok), .o_select_n(o_select_n), .o_write_n(o_write_n),
    .o_out_enable_n(o_out_enable_n), .o_upper_lane_enable_n(o_upper_lane_enable_n),
    .o_lower_lane_enable_n(o_lower_lane_enable_n), .o_address_bus(o_address_bus), .o_data_bus_oe(o_data_bus_oe));

// ==== bench/sram_device_model.sv ====
`timescale 1ns/1ps
module sram_device_model #(
    parameter int ACCESS_NS = 40
) (
    input wire logic i_select_n, // Chip select.
    input wire logic i_write_n, // Write strobe.
    input wire logic i_out_enable_n, // Output enable.
    input wire logic i_upper_lane_enable_n, // Upper lane.
    input wire logic i_lower_lane_enable_n, // Lower lane.
    input wire logic [17:0] i_address_bus, // Address pins.
    input wire logic [15:0] i_data_bus, // Wire value.
    output logic [15:0] o_data_bus, // Memory output.
    output logic [1:0] o_lane_drive // Lanes driven.
);
    logic [15:0] mem [logic [17:0]];
    logic [15:0] word;
    logic [15:0] word_now;
    logic [15:0] word_dly;
    logic strobe_ok = 1'b0;
    logic writing;
    assign writing = !i_select_n && !i_write_n && !(i_upper_lane_enable_n && i_lower_lane_enable_n);
    always @(negedge writing) begin
        if ($time > 0) begin
            word = mem.exists(i_address_bus) ? mem[i_address_bus] : 16'h0000;
            if (!i_lower_lane_enable_n) word[7:0] = i_data_bus[7:0];
            if (!i_upper_lane_enable_n) word[15:8] = i_data_bus[15:8];
            mem[i_address_bus] = word;
            // The read path is refreshed here as well, so it never races the store.
            word_now = word;
        end
    end
    always @(i_address_bus or writing) begin
        word_now = mem.exists(i_address_bus) ? mem[i_address_bus] : 16'h0000;
    end
    assign #(ACCESS_NS) word_dly = word_now;
    always @(i_write_n) begin
        if (i_write_n) strobe_ok <= #(sram_host_pkg::STROBE_HIGH_TO_DRIVE_DELAY_NS) 1'b1;
        else strobe_ok = 1'b0;
    end
    assign o_lane_drive = (!i_select_n && !i_out_enable_n && i_write_n && strobe_ok) ?
        ~{i_upper_lane_enable_n, i_lower_lane_enable_n} : 2'h0;
    // An undriven lane shows the inverse so stale data never passes.
    assign o_data_bus = {o_lane_drive[1] ? word_dly[15:8] : ~word_dly[15:8],
        o_lane_drive[0] ? word_dly[7:0] : ~word_dly[7:0]};
endmodule : sram_device_model

// ==== bench/tb_sram_write_host.sv ====
`timescale 1ns/1ps
module tb_sram_write_host;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_req_valid = 1'b0;
    sram_host_pkg::sram_req_type i_req = '0;
    logic i_retain_req = 1'b0;
    logic o_req_ready, o_rd_valid, o_retain_ok, o_select_n, o_write_n, o_out_enable_n;
    logic o_upper_lane_enable_n, o_lower_lane_enable_n, o_data_bus_oe;
    logic [15:0] o_rd_data, o_data_bus_out, dev_data, bus;
    logic [17:0] o_address_bus;
    logic [1:0] dev_drive;
    logic [17:0] pool [0:7];
    logic [15:0] shadow [logic [17:0]];
    logic [1:0] corner [0:3] = '{2'h3, 2'h1, 2'h2, 2'h0};
    logic [31:0] seed = 32'hf9550b4f;
    logic [31:0] r;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #2.5 i_clk = ~i_clk;
    assign bus = o_data_bus_oe ? o_data_bus_out : dev_data;
    sram_write_host sram_write_host_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
        .i_retain_req(i_retain_req), .o_retain_ok(o_retain_ok), .o_select_n(o_select_n), .o_write_n(o_write_n),
        .o_out_enable_n(o_out_enable_n), .o_upper_lane_enable_n(o_upper_lane_enable_n),
        .o_lower_lane_enable_n(o_lower_lane_enable_n), .o_address_bus(o_address_bus),
        .o_data_bus_out(o_data_bus_out), .o_data_bus_oe(o_data_bus_oe), .i_data_bus_in(bus));
    sram_device_model sram_device_model_inst (.i_select_n(o_select_n), .i_write_n(o_write_n),
        .i_out_enable_n(o_out_enable_n), .i_upper_lane_enable_n(o_upper_lane_enable_n),
        .i_lower_lane_enable_n(o_lower_lane_enable_n), .i_address_bus(o_address_bus), .i_data_bus(bus),
        .o_data_bus(dev_data), .o_lane_drive(dev_drive));
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: flag got %h expected %h", $time, got, exp);
        end
    endtask : check_bit
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask : step
    task automatic do_req(input logic wr, input logic [17:0] a, input logic [15:0] d, input logic [1:0] ln);
        logic rdy;
        logic [15:0] m;
        logic [15:0] old;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        old = shadow.exists(a) ? shadow[a] : 16'h0000;
        i_req_valid = 1'b1;
        i_req = '{wr, a, d, ln};
        do begin
            rdy = o_req_ready;
            step();
        end while (rdy !== 1'b1);
        i_req_valid = 1'b0;
        if (wr) begin
            shadow[a] = (old & ~m) | (d & m);
            step();
        end else begin
            while (o_rd_valid !== 1'b1) begin
                step();
            end
            check_word(o_rd_data, old & m);
        end
    endtask : do_req
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (o_data_bus_oe === 1'b1) check_bit(dev_drive == 2'h0, 1'b1);
        if (cycles == 12000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        int n;
        logic held;
        for (int k = 0; k < 8; k++) begin
            r = next_rand();
            pool[k] = r[17:0];
        end
        repeat (20) step();
        check_bit(o_select_n & o_write_n & ~o_data_bus_oe & ~o_req_ready, 1'b1);
        i_reset_n = 1'b1;
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            r = next_rand();
            do_req(1'b1, pool[0], r[15:0], corner[k]);
            do_req(1'b0, pool[0], 16'h0000, 2'h3);
        end
        $display("test lane corners done");
        for (int k = 0; k < 60; k++) begin
            r = next_rand();
            do_req(r[0], pool[r[3:1]], r[19:4], r[21:20]);
        end
        $display("test random traffic done");
        i_retain_req = 1'b1;
        i_req_valid = 1'b1;
        i_req = '{1'b1, pool[1], 16'h5aa5, 2'h3};
        for (n = 0; n < 40 && o_retain_ok !== 1'b1; n++) step();
        check_bit(o_retain_ok & o_lower_lane_enable_n & o_upper_lane_enable_n, 1'b1);
        held = 1'b1;
        repeat (20) begin
            step();
            held &= o_select_n;
        end
        check_bit(held, 1'b1);
        i_req_valid = 1'b0;
        i_retain_req = 1'b0;
        for (n = 0; n < 40 && o_req_ready !== 1'b1; n++) step();
        check_bit(n >= 12, 1'b1);
        $display("test retention done");
        for (int k = 0; k < 8; k++) do_req(1'b0, pool[k], 16'h0000, 2'h3);
        $display("test sweep done");
        end_of_test();
    end
endmodule : tb_sram_write_host
